// ---- verilog/canmo_setup.sv ----
// Message-object configuration and acceptance filtering of a CAN node.
// Assumes a frame decoder outside delivers identifier, format, remote
// bit and length as one-cycle strobes, and a bit timer gives a bit strobe.
`timescale 1ns/100ps
`include "canmo_cfg.svh"
module canmo_setup
	import canmo_pkg::*;
#(
	parameter int NUM_OBJ = 15
) (
	input  wire logic        I_REF_CLK,
	input  wire logic        I_RST,
	input  wire logic [15:0] I_ADDR,
	input  wire logic [15:0] I_WDATA,
	input  wire logic        I_WR,
	input  wire logic        I_RD,
	output logic      [15:0] O_RDATA,
	input  wire logic        I_BIT_TICK,
	input  wire logic        I_RX_PIN,
	input  wire logic        I_FRM_VALID,
	input  wire logic [28:0] I_FRM_ID,
	input  wire logic        I_FRM_XTD,
	input  wire logic        I_FRM_RMT,
	input  wire logic [3:0]  I_FRM_DLC,
	input  wire logic        I_TX_DONE,
	input  wire logic        I_STATUS_EVT,
	input  wire logic        I_ERROR_EVT,
	output logic             O_BUS_ON,
	output logic             O_TX_REQ,
	output logic      [3:0]  O_TX_OBJ,
	output logic             O_TX_RMT,
	output logic             O_STORE,
	output logic      [3:0]  O_STORE_OBJ,
	output logic             O_IRQ
);
	localparam int LAST = NUM_OBJ - 1;

	logic [15:0] ctrl_reg, ctrl_next;
	logic [15:0] gsm_reg, gsm_next;
	logic [15:0] glu_reg, glu_next;
	logic [15:0] gll_reg, gll_next;
	logic [15:0] cmu_reg, cmu_next;
	logic [15:0] cml_reg, cml_next;
	logic [7:0]  flg_reg [NUM_OBJ];
	logic [7:0]  flg_next [NUM_OBJ];
	logic [15:0] aup_reg [NUM_OBJ];
	logic [15:0] aup_next [NUM_OBJ];
	logic [15:0] alo_reg [NUM_OBJ];
	logic [15:0] alo_next [NUM_OBJ];
	logic [7:0]  cfg_reg [NUM_OBJ];
	logic [7:0]  cfg_next [NUM_OBJ];
	logic [15:0] rdata_reg, rdata_next;
	logic        rx_s1_reg, rx_s2_reg;
	logic [3:0]  idle_reg, idle_next;
	canmo_state_t st_reg, st_next;
	logic        tx_busy_reg, tx_busy_next;
	logic [3:0]  tx_obj_reg, tx_obj_next;
	logic        tx_rmt_reg, tx_rmt_next;
	logic        store_reg, store_next;
	logic [3:0]  sobj_reg, sobj_next;
	logic        irq_reg, irq_next;

	logic [28:0] gmask;
	logic [28:0] cmask;
	logic [28:0] obj_id [NUM_OBJ];
	logic [NUM_OBJ-1:0] hit, wr_ctl, wr_aup, wr_alo, wr_cfg;
	logic [NUM_OBJ-1:0] hit_rx_data, hit_tx_rmt, pend;
	logic [7:0]  hw_set [NUM_OBJ];
	logic [7:0]  hw_clr [NUM_OBJ];
	logic        cfg_open, bus_on;

	// Long masks: upper word bytes swapped, lower word bits 10:8 unused.
	function automatic logic [28:0] unpack_id(input logic [15:0] up,
		input logic [15:0] lo);
		unpack_id = {up[7:0], up[15:8], lo[7:0], lo[15:11]};
	endfunction : unpack_id

	always_comb begin
		gmask = unpack_id(glu_reg, gll_reg);
		// Short mask uses the upper-word layout, top 11 bits only
		if (!I_FRM_XTD) begin
			gmask = {gsm_reg[7:0], gsm_reg[15:13], 18'h0};
		end
		cmask = unpack_id(cmu_reg, cml_reg);
	end

	assign cfg_open = ctrl_reg[`CANMO_CTRL_CCE];
	assign bus_on   = (st_reg == CANMO_ST_ACTIVE);

	genvar n;
	generate
		for (n = 0; n < NUM_OBJ; n++) begin : g_obj
			logic [28:0] m;
			logic [15:0] base;
			logic [28:0] diff;
			assign base = 16'(`CANMO_OFF_OBJ_BASE + n * `CANMO_OBJ_STRIDE);
			assign wr_ctl[n] = I_WR && I_ADDR == (base | `CANMO_OBJ_CTL);
			assign wr_aup[n] = I_WR && I_ADDR == (base | `CANMO_OBJ_AUP);
			assign wr_alo[n] = I_WR && I_ADDR == (base | `CANMO_OBJ_ALO);
			assign wr_cfg[n] = I_WR && I_ADDR == (base | `CANMO_OBJ_CFG);
			assign obj_id[n] = unpack_id(aup_reg[n], alo_reg[n]);
			assign m = (n == LAST) ? (gmask & cmask) : gmask;
			assign diff = (obj_id[n] ^ I_FRM_ID) & m;
			assign hit[n] = bus_on && I_FRM_VALID
				&& flg_reg[n][`CANMO_FLG_VALID]
				&& (cfg_reg[n][`CANMO_CFG_XTD] == I_FRM_XTD)
				&& (I_FRM_XTD ? diff == 29'h0 : diff[28:18] == 11'h0);
			assign hit_rx_data[n] = hit[n] && !I_FRM_RMT
				&& !cfg_reg[n][`CANMO_CFG_DIR];
			assign hit_tx_rmt[n] = hit[n] && I_FRM_RMT
				&& cfg_reg[n][`CANMO_CFG_DIR];
			assign pend[n] = bus_on && flg_reg[n][`CANMO_FLG_VALID]
				&& flg_reg[n][`CANMO_FLG_SEND]
				&& !(cfg_reg[n][`CANMO_CFG_DIR]
				&& flg_reg[n][`CANMO_FLG_HOSTUPD]);
			canmo_flag_update u_flags (
				.i_cur    (flg_reg[n]),
				.i_wr     (wr_ctl[n]),
				.i_wdata  (I_WDATA),
				.i_hw_set (hw_set[n]),
				.i_hw_clr (hw_clr[n]),
				.o_next   (flg_next[n])
			);
		end
	endgenerate

	// Frame acceptance and object flag updates
	always_comb begin
		logic        taken;
		logic        cand;
		logic [NUM_OBJ-1:0] win;
		cand  = 1'b0;
		taken = 1'b0;
		win   = '0;
		for (int k = 0; k < LAST; k++) begin
			cand = hit_rx_data[k] || hit_tx_rmt[k];
			if (cand && !taken) begin
				win[k] = 1'b1;
				taken  = 1'b1;
			end
		end
		if (!taken && (hit_rx_data[LAST] || hit_tx_rmt[LAST])) begin
			win[LAST] = 1'b1;
		end
		store_next = |(win & hit_rx_data);
		sobj_next  = sobj_reg;
		for (int k = 0; k < NUM_OBJ; k++) begin
			hw_set[k] = 8'h00;
			hw_clr[k] = 8'h00;
			aup_next[k] = aup_reg[k];
			alo_next[k] = alo_reg[k];
			cfg_next[k] = cfg_reg[k];
			if (wr_ctl[k] && I_WDATA == `CANMO_CTL_RESET) begin
				hw_clr[k] = 8'hff;
			end
			if (wr_aup[k] && cfg_open) begin
				aup_next[k] = I_WDATA;
			end
			if (wr_alo[k] && cfg_open) begin
				alo_next[k] = I_WDATA & 16'hfff8;
			end
			if (wr_cfg[k] && cfg_open) begin
				cfg_next[k] = I_WDATA[7:0];
				if (I_WDATA[7:4] > `CANMO_DLC_MAX) begin
					cfg_next[k][7:4] = `CANMO_DLC_MAX;
				end
			end
			if (win[k] && hit_rx_data[k]) begin
				sobj_next = 4'(k);
				hw_set[k][`CANMO_FLG_FRESH] = 1'b1;
				if (flg_reg[k][`CANMO_FLG_FRESH]) begin
					hw_set[k][`CANMO_FLG_HOSTUPD] = 1'b1;
				end
				if (flg_reg[k][`CANMO_FLG_RX_IRQ_ENABLE]) begin
					hw_set[k][`CANMO_FLG_IRQ] = 1'b1;
				end
				cfg_next[k][7:4] = I_FRM_DLC;
				aup_next[k] = {I_FRM_ID[20:13], I_FRM_ID[28:21]};
				alo_next[k] = {I_FRM_ID[4:0], 3'h0, I_FRM_ID[12:5]};
			end
			if (win[k] && hit_tx_rmt[k]) begin
				hw_set[k][`CANMO_FLG_SEND] = 1'b1;
				hw_set[k][`CANMO_FLG_RMT]  = 1'b1;
				cfg_next[k][7:4] = I_FRM_DLC;
				if (flg_reg[k][`CANMO_FLG_RX_IRQ_ENABLE]) begin
					hw_set[k][`CANMO_FLG_IRQ] = 1'b1;
				end
			end
			if (I_TX_DONE && tx_busy_reg && tx_obj_reg == 4'(k)) begin
				hw_clr[k][`CANMO_FLG_SEND] = 1'b1;
				hw_clr[k][`CANMO_FLG_RMT]  = 1'b1;
				if (flg_reg[k][`CANMO_FLG_TX_IRQ_ENABLE]) begin
					hw_set[k][`CANMO_FLG_IRQ] = 1'b1;
				end
			end
		end
	end

	// Transmit request: lowest pending object, held until done or bus off
	always_comb begin
		logic found;
		found = 1'b0;
		tx_busy_next = tx_busy_reg;
		tx_obj_next  = tx_obj_reg;
		tx_rmt_next  = tx_rmt_reg;
		if (tx_busy_reg && (I_TX_DONE || !bus_on)) begin
			tx_busy_next = 1'b0;
		end else if (!tx_busy_reg) begin
			for (int k = 0; k < NUM_OBJ; k++) begin
				if (pend[k] && !found) begin
					found        = 1'b1;
					tx_busy_next = 1'b1;
					tx_obj_next  = 4'(k);
					// Receive object asks for data by remote frame
					tx_rmt_next  = !cfg_reg[k][`CANMO_CFG_DIR];
				end
			end
		end
	end

	// Control register and global masks
	always_comb begin
		ctrl_next = ctrl_reg;
		gsm_next  = gsm_reg;
		glu_next  = glu_reg;
		gll_next  = gll_reg;
		cmu_next  = cmu_reg;
		cml_next  = cml_reg;
		if (I_WR) begin
			case (I_ADDR)
				`CANMO_OFF_CTRL: begin
					ctrl_next = I_WDATA & 16'h004f;
				end
				`CANMO_OFF_GSMASK: begin
					if (cfg_open) gsm_next = I_WDATA & 16'he0ff;
				end
				`CANMO_OFF_GLM_UP: begin
					if (cfg_open) glu_next = I_WDATA;
				end
				`CANMO_OFF_GLM_LO: begin
					if (cfg_open) gll_next = I_WDATA & 16'hf8ff;
				end
				`CANMO_OFF_CAM_UP: begin
					if (cfg_open) cmu_next = I_WDATA;
				end
				`CANMO_OFF_CAM_LO: begin
					if (cfg_open) cml_next = I_WDATA & 16'hf8ff;
				end
				default: begin
				end
			endcase
		end
	end

	// Bus-off-to-on sequencing
	always_comb begin
		st_next   = st_reg;
		idle_next = idle_reg;
		case (st_reg)
			CANMO_ST_CONFIG: begin
				idle_next = 4'h0;
				if (!ctrl_reg[`CANMO_CTRL_HOLD] && !cfg_open) begin
					st_next = CANMO_ST_SYNC;
				end
			end
			CANMO_ST_SYNC: begin
				if (I_BIT_TICK) begin
					// Dominant bit restarts the idle count
					idle_next = rx_s2_reg ? idle_reg + 4'h1 : 4'h0;
					if (rx_s2_reg && idle_reg == `CANMO_IDLE_BITS - 4'h1) begin
						st_next = CANMO_ST_ACTIVE;
					end
				end
			end
			CANMO_ST_ACTIVE: begin
				idle_next = 4'h0;
			end
			default: begin
				st_next = CANMO_ST_CONFIG;
			end
		endcase
		if (ctrl_reg[`CANMO_CTRL_HOLD]) begin
			st_next = CANMO_ST_CONFIG;
		end
	end

	// Read mux and interrupt gating
	always_comb begin
		logic any_obj_irq;
		any_obj_irq = 1'b0;
		rdata_next  = 16'h0000;
		for (int k = 0; k < NUM_OBJ; k++) begin
			any_obj_irq = any_obj_irq || flg_reg[k][`CANMO_FLG_IRQ];
			if (I_ADDR == 16'(`CANMO_OFF_OBJ_BASE + k * `CANMO_OBJ_STRIDE)) begin
				for (int b = 0; b < 8; b++) begin
					rdata_next[2*b+1 -: 2] = flg_reg[k][b] ? 2'b10 : 2'b01;
				end
			end
			if (I_ADDR == 16'(`CANMO_OFF_OBJ_BASE + k * `CANMO_OBJ_STRIDE + 2))
				rdata_next = aup_reg[k];
			if (I_ADDR == 16'(`CANMO_OFF_OBJ_BASE + k * `CANMO_OBJ_STRIDE + 4))
				rdata_next = alo_reg[k];
			if (I_ADDR == 16'(`CANMO_OFF_OBJ_BASE + k * `CANMO_OBJ_STRIDE + 6))
				rdata_next = {8'h00, cfg_reg[k]};
		end
		case (I_ADDR)
			`CANMO_OFF_CTRL:   rdata_next = {7'h00, bus_on, ctrl_reg[7:0]};
			`CANMO_OFF_GSMASK: rdata_next = gsm_reg;
			`CANMO_OFF_GLM_UP: rdata_next = glu_reg;
			`CANMO_OFF_GLM_LO: rdata_next = gll_reg;
			`CANMO_OFF_CAM_UP: rdata_next = cmu_reg;
			`CANMO_OFF_CAM_LO: rdata_next = cml_reg;
			default: begin
			end
		endcase
		if (!I_RD) begin
			rdata_next = 16'h0000;
		end
		irq_next = ctrl_reg[`CANMO_CTRL_GIE] && (any_obj_irq
			|| (ctrl_reg[`CANMO_CTRL_SIE] && I_STATUS_EVT)
			|| (ctrl_reg[`CANMO_CTRL_EIE] && I_ERROR_EVT));
	end

	always_ff @(posedge I_REF_CLK) begin
		rx_s1_reg <= I_RX_PIN;
		rx_s2_reg <= rx_s1_reg;
		if (I_RST) begin
			ctrl_reg    <= `CANMO_CTRL_RESET;
			gsm_reg     <= 16'h0000;
			glu_reg     <= 16'h0000;
			gll_reg     <= 16'h0000;
			cmu_reg     <= 16'h0000;
			cml_reg     <= 16'h0000;
			rdata_reg   <= 16'h0000;
			idle_reg    <= 4'h0;
			st_reg      <= CANMO_ST_CONFIG;
			tx_busy_reg <= 1'b0;
			tx_obj_reg  <= 4'h0;
			tx_rmt_reg  <= 1'b0;
			store_reg   <= 1'b0;
			sobj_reg    <= 4'h0;
			irq_reg     <= 1'b0;
			for (int k = 0; k < NUM_OBJ; k++) begin
				flg_reg[k] <= 8'h00;
				aup_reg[k] <= 16'h0000;
				alo_reg[k] <= 16'h0000;
				cfg_reg[k] <= 8'h00;
			end
		end else begin
			ctrl_reg    <= ctrl_next;
			gsm_reg     <= gsm_next;
			glu_reg     <= glu_next;
			gll_reg     <= gll_next;
			cmu_reg     <= cmu_next;
			cml_reg     <= cml_next;
			rdata_reg   <= rdata_next;
			idle_reg    <= idle_next;
			st_reg      <= st_next;
			tx_busy_reg <= tx_busy_next;
			tx_obj_reg  <= tx_obj_next;
			tx_rmt_reg  <= tx_rmt_next;
			store_reg   <= store_next;
			sobj_reg    <= sobj_next;
			irq_reg     <= irq_next;
			for (int k = 0; k < NUM_OBJ; k++) begin
				flg_reg[k] <= flg_next[k];
				aup_reg[k] <= aup_next[k];
				alo_reg[k] <= alo_next[k];
				cfg_reg[k] <= cfg_next[k];
			end
		end
	end

	assign O_RDATA     = rdata_reg;
	assign O_BUS_ON    = bus_on;
	assign O_TX_REQ    = tx_busy_reg;
	assign O_TX_OBJ    = tx_obj_reg;
	assign O_TX_RMT    = tx_rmt_reg;
	assign O_STORE     = store_reg;
	assign O_STORE_OBJ = sobj_reg;
	assign O_IRQ       = irq_reg;
endmodule : canmo_setup

// ---- include/canmo_cfg.svh ----
// Offsets, field positions, reset values and timing counts of the
// message-object setup block. Included by its bare name.
`ifndef CANMO_CFG_SVH
`define CANMO_CFG_SVH
`define CANMO_OFF_CTRL      16'hef00
`define CANMO_OFF_GSMASK    16'hef06
`define CANMO_OFF_GLM_UP    16'hef08
`define CANMO_OFF_GLM_LO    16'hef0a
`define CANMO_OFF_CAM_UP    16'hef0c
`define CANMO_OFF_CAM_LO    16'hef0e
`define CANMO_OFF_OBJ_BASE  16'hef10
`define CANMO_OBJ_STRIDE    16'h0010
`define CANMO_OBJ_CTL       4'h0
`define CANMO_OBJ_AUP       4'h2
`define CANMO_OBJ_ALO       4'h4
`define CANMO_OBJ_CFG       4'h6
`define CANMO_CTRL_HOLD     0
`define CANMO_CTRL_GIE      1
`define CANMO_CTRL_SIE      2
`define CANMO_CTRL_EIE      3
`define CANMO_CTRL_CCE      6
`define CANMO_CTRL_RESET    16'h0041
`define CANMO_FLG_IRQ       0
`define CANMO_FLG_RX_IRQ_ENABLE      1
`define CANMO_FLG_TX_IRQ_ENABLE      2
`define CANMO_FLG_VALID     3
`define CANMO_FLG_FRESH     4
`define CANMO_FLG_HOSTUPD   5
`define CANMO_FLG_SEND      6
`define CANMO_FLG_RMT       7
`define CANMO_CTL_RESET     16'h5555
`define CANMO_CFG_DIR       3
`define CANMO_CFG_XTD       2
`define CANMO_DLC_MAX       4'h8
`define CANMO_IDLE_BITS     4'hb
`endif

// ---- include/canmo_pkg.sv ----
// Types shared by the message-object setup block.
package canmo_pkg;
	typedef enum logic [2:0] {
		CANMO_ST_CONFIG = 3'b001,
		CANMO_ST_SYNC   = 3'b010,
		CANMO_ST_ACTIVE = 3'b100
	} canmo_state_t;
endpackage : canmo_pkg

// ---- verilog/canmo_flag_update.sv ----
// Two-bit set/clear decode for the eight flags of one object control word.
// Assumes the caller supplies hardware set and clear requests per flag.
`timescale 1ns/100ps
module canmo_flag_update (
	input  wire logic [7:0]  i_cur,
	input  wire logic        i_wr,
	input  wire logic [15:0] i_wdata,
	input  wire logic [7:0]  i_hw_set,
	input  wire logic [7:0]  i_hw_clr,
	output logic      [7:0]  o_next
);
	genvar g;
	generate
		for (g = 0; g < 8; g++) begin : g_flag
			logic [1:0] pair;
			logic       sw;
			assign pair = i_wdata[2*g+1:2*g];
			always_comb begin
				sw = i_cur[g];
				if (i_wr && pair == 2'b10) begin
					sw = 1'b1;
				end else if (i_wr && pair == 2'b01) begin
					sw = 1'b0;
				end
				// Pattern 11 or 00 keeps the flag
				if (i_hw_clr[g]) begin
					sw = 1'b0;
				end
				// Hardware set wins over any clear
				if (i_hw_set[g]) begin
					sw = 1'b1;
				end
				o_next[g] = sw;
			end
		end
	endgenerate
endmodule : canmo_flag_update

// ---- verif/canmo_setup_sva.sv ----
// Port-level assertions for the message-object setup block.
// Assumes one clock domain and the synchronous active-high reset.
`timescale 1ns/100ps
`include "canmo_cfg.svh"
module canmo_setup_sva #(
	parameter int NUM_OBJ = 15
) (
	input wire logic        I_REF_CLK,
	input wire logic        I_RST,
	input wire logic [15:0] I_ADDR,
	input wire logic        I_WR,
	input wire logic        I_RD,
	input wire logic [15:0] O_RDATA,
	input wire logic        I_BIT_TICK,
	input wire logic        I_RX_PIN,
	input wire logic        I_FRM_VALID,
	input wire logic        I_TX_DONE,
	input wire logic        I_STATUS_EVT,
	input wire logic        I_ERROR_EVT,
	input wire logic        O_BUS_ON,
	input wire logic        O_TX_REQ,
	input wire logic [3:0]  O_TX_OBJ,
	input wire logic        O_TX_RMT,
	input wire logic        O_STORE,
	input wire logic [3:0]  O_STORE_OBJ,
	input wire logic        O_IRQ
);
	logic [1:0] rx_reg, rx_next;
	logic [4:0] cnt_reg, cnt_next;
	logic       src;
	assign src = I_STATUS_EVT | I_ERROR_EVT | I_FRM_VALID | I_TX_DONE | I_WR;
	// Recessive ticks since the last control write or dominant tick, two-flop pin lag
	always_comb begin
		rx_next = {rx_reg[0], I_RX_PIN};
		cnt_next = cnt_reg;
		if ((I_WR && I_ADDR == `CANMO_OFF_CTRL) || (I_BIT_TICK && !rx_reg[1]))
			cnt_next = 5'h00;
		else if (I_BIT_TICK && cnt_reg != 5'h1f)
			cnt_next = cnt_reg + 5'h01;
	end
	always_ff @(posedge I_REF_CLK) begin
		if (I_RST) begin
			rx_reg  <= 2'h3;
			cnt_reg <= 5'h00;
		end else begin
			rx_reg  <= rx_next;
			cnt_reg <= cnt_next;
		end
	end
	default clocking cb @(posedge I_REF_CLK); endclocking
	default disable iff (I_RST);
	rd_idle_a: assert property (!$past(I_RD) |-> O_RDATA == 16'h0000)
		else $error("read data not idle");
	unmapped_zero_a: assert property ($past(I_RD && (I_ADDR < 16'hef00))
		|-> O_RDATA == 16'h0000) else $error("unmapped read not zero");
	store_cause_a: assert property (O_STORE |-> $past(I_FRM_VALID && O_BUS_ON))
		else $error("store without frame");
	store_index_a: assert property (O_STORE |-> O_STORE_OBJ < NUM_OBJ)
		else $error("store index out of range");
	bus_join_a: assert property ($rose(O_BUS_ON) |-> cnt_reg >= 5'h0b)
		else $error("joined bus too early");
	tx_hold_a: assert property (O_TX_REQ && !I_TX_DONE |=> O_TX_REQ
		&& $stable(O_TX_OBJ) && $stable(O_TX_RMT)) else $error("tx not held");
	tx_release_a: assert property (O_TX_REQ && I_TX_DONE |=> !O_TX_REQ)
		else $error("tx not released");
	irq_cause_a: assert property ($rose(O_IRQ) |-> $past(src)
		|| $past(src, 2) || $past(src, 3)) else $error("irq without cause");
endmodule : canmo_setup_sva
bind canmo_setup canmo_setup_sva #(.NUM_OBJ(NUM_OBJ)) u_sva (.*);

// ---- verif/canmo_bus_model.sv ----
// Stand-in for the bus side: bit ticks, decoded frames, transmit done.
// Assumes the shared clock; the idle bus is recessive (pulled high).
`timescale 1ns/100ps
module canmo_bus_model (
	input  wire logic        i_clk,
	output logic             o_tick,
	output logic             o_rx,
	output logic             o_valid,
	output logic      [28:0] o_id,
	output logic             o_xtd,
	output logic             o_rmt,
	output logic      [3:0]  o_dlc,
	output logic             o_done
);
	initial begin
		o_tick = 1'b0;
		o_rx = 1'b1;
		o_valid = 1'b0;
		o_id = '0;
		o_xtd = 1'b0;
		o_rmt = 1'b0;
		o_dlc = 4'h0;
		o_done = 1'b0;
	end
	task automatic idle(input int n);
		repeat (n) begin
			@(posedge i_clk);
			o_tick <= 1'b1;
			@(posedge i_clk);
			o_tick <= 1'b0;
			repeat (2) @(posedge i_clk);
		end
	endtask : idle
	task automatic frame(input logic [10:0] s, input logic x, input logic r);
		@(posedge i_clk);
		o_valid <= 1'b1;
		o_id    <= {s, 18'h00000};
		o_xtd   <= x;
		o_rmt   <= r;
		o_dlc   <= 4'h4;
		@(posedge i_clk);
		// Stale fields flip so a late sample cannot pass
		o_valid <= 1'b0;
		o_id    <= ~o_id;
		o_xtd   <= ~x;
		o_rmt   <= ~r;
		o_dlc   <= 4'hb;
	endtask : frame
	task automatic done();
		@(posedge i_clk);
		o_done <= 1'b1;
		@(posedge i_clk);
		o_done <= 1'b0;
	endtask : done
endmodule : canmo_bus_model

// ---- verif/canmo_setup_tb.sv ----
// Self-checking bench for the message-object setup block.
// Assumes the bus model drives ticks, frames and transmit done.
`timescale 1ns/100ps
`include "canmo_cfg.svh"
module canmo_setup_tb;
	localparam logic [7:0]  IRQ = 8'h01;
	localparam logic [7:0]  RXE = 8'h02;
	localparam logic [7:0]  TXE = 8'h04;
	localparam logic [7:0]  VAL = 8'h08;
	localparam logic [7:0]  HUP = 8'h20;
	localparam logic [7:0]  SND = 8'h40;
	localparam logic [15:0] CT  = `CANMO_OFF_CTRL;
	logic        I_REF_CLK, I_RST, I_WR, I_RD, I_STATUS_EVT, I_ERROR_EVT;
	logic [15:0] I_ADDR, I_WDATA, O_RDATA, rv;
	logic [28:0] I_FRM_ID;
	logic [3:0]  I_FRM_DLC, O_TX_OBJ, O_STORE_OBJ;
	logic        I_BIT_TICK, I_RX_PIN, I_FRM_VALID, I_FRM_XTD, I_FRM_RMT;
	logic        I_TX_DONE, O_BUS_ON, O_TX_REQ, O_TX_RMT, O_STORE, O_IRQ;
	int          n_fail, tests_run;

	canmo_setup #(.NUM_OBJ(15)) u_dut (.*);
	canmo_bus_model u_bus (
		.i_clk   (I_REF_CLK),
		.o_tick  (I_BIT_TICK),
		.o_rx    (I_RX_PIN),
		.o_valid (I_FRM_VALID),
		.o_id    (I_FRM_ID),
		.o_xtd   (I_FRM_XTD),
		.o_rmt   (I_FRM_RMT),
		.o_dlc   (I_FRM_DLC),
		.o_done  (I_TX_DONE)
	);

	function automatic logic [15:0] oc(input int n);
		return `CANMO_OFF_OBJ_BASE + 16'(n) * `CANMO_OBJ_STRIDE;
	endfunction : oc
	function automatic logic [15:0] cw(input logic [7:0] s, input logic [7:0] c);
		for (int b = 0; b < 8; b++)
			cw[2*b+:2] = s[b] ? 2'b10 : (c[b] ? 2'b01 : 2'b11);
	endfunction : cw
	task automatic stop_test();
		if (n_fail == 0 && tests_run > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : stop_test
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		tests_run++;
		if (g !== e) begin
			n_fail++;
			$display("[ERR] %0t got %h want %h", $time, g, e);
		end
	endtask : chk
	task automatic chk1(input logic g, input logic e);
		chk(16'(g), 16'(e));
	endtask : chk1
	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		@(posedge I_REF_CLK);
		I_WR    <= 1'b1;
		I_ADDR  <= a;
		I_WDATA <= d;
		@(posedge I_REF_CLK);
		I_WR <= 1'b0;
	endtask : wr
	task automatic rd(input logic [15:0] a, output logic [15:0] d);
		@(posedge I_REF_CLK);
		I_RD   <= 1'b1;
		I_ADDR <= a;
		@(posedge I_REF_CLK);
		I_RD <= 1'b0;
		#1;
		d = O_RDATA;
	endtask : rd
	task automatic rc(input logic [15:0] a, input logic [15:0] e);
		rd(a, rv);
		chk(rv, e);
	endtask : rc
	// Standard id lands in bits 28:18, upper word holds them byte-swapped
	task automatic obj(input int n, input logic [10:0] s, input logic [15:0] c,
			input logic [15:0] f);
		wr(oc(n) + 16'h0002, {s[2:0], 5'h00, s[10:3]});
		wr(oc(n) + 16'h0004, 16'h0000);
		wr(oc(n) + 16'h0006, c);
		wr(oc(n), f);
	endtask : obj
	task automatic fr(input logic [10:0] s, input logic x, input logic st,
			input logic [3:0] ob);
		u_bus.frame(s, x, 1'b0);
		#1;
		chk1(O_STORE, st);
		if (st)
			chk(16'(O_STORE_OBJ), 16'(ob));
	endtask : fr
	task automatic tw(input logic e, input logic [3:0] ob, input logic rm);
		repeat (3) @(posedge I_REF_CLK);
		#1;
		chk1(O_TX_REQ, e);
		if (e) begin
			chk(16'(O_TX_OBJ), 16'(ob));
			chk1(O_TX_RMT, rm);
		end
	endtask : tw
	task automatic iw(input logic e);
		repeat (3) @(posedge I_REF_CLK);
		#1;
		chk1(O_IRQ, e);
	endtask : iw

	initial begin
		I_REF_CLK = 1'b0;
		forever #50 I_REF_CLK = ~I_REF_CLK;
	end
	initial begin
		// Roughly fifty times the expected run
		#1000000;
		n_fail++;
		stop_test();
	end
	initial begin
		{I_RST, I_WR, I_RD, I_STATUS_EVT, I_ERROR_EVT} = 5'b10000;
		I_ADDR = 16'h0000;
		I_WDATA = 16'h0000;
		n_fail = 0;
		tests_run = 0;
		repeat (16) @(posedge I_REF_CLK);
		I_RST <= 1'b0;
		rc(CT, `CANMO_CTRL_RESET);
		rc(16'h0100, 16'h0000);
		wr(`CANMO_OFF_GSMASK, 16'he0ff);
		wr(`CANMO_OFF_GLM_UP, 16'hffff);
		wr(`CANMO_OFF_GLM_LO, 16'hf8ff);
		rc(`CANMO_OFF_GLM_LO, 16'hf8ff);
		wr(`CANMO_OFF_CAM_UP, 16'h0000);
		wr(`CANMO_OFF_CAM_LO, 16'h0000);
		obj(0, 11'h347, 16'h0040, 16'h5599);
		obj(1, 11'h123, 16'h0088, cw(VAL | HUP | TXE, 8'hff));
		obj(14, 11'h000, 16'h0000, cw(VAL, 8'hff));
		rc(oc(0) + 16'h0002, 16'he068);
		rc(oc(0), 16'h5599);
		wr(oc(2) + 16'h0006, 16'h00f4);
		rc(oc(2) + 16'h0006, 16'h0084);
		wr(CT, 16'h000e);
		rc(CT, 16'h000e);
		wr(oc(0) + 16'h0002, 16'h1234);
		rc(oc(0) + 16'h0002, 16'he068);
		u_bus.idle(10);
		#1;
		chk1(O_BUS_ON, 1'b0);
		u_bus.idle(1);
		#1;
		chk1(O_BUS_ON, 1'b1);
		rc(CT, 16'h010e);
		fr(11'h347, 1'b0, 1'b1, 4'h0);
		iw(1'b1);
		wr(oc(0), cw(8'h00, IRQ));
		iw(1'b0);
		fr(11'h346, 1'b0, 1'b1, 4'he);
		fr(11'h347, 1'b1, 1'b0, 4'h0);
		fr(11'h347, 1'b0, 1'b1, 4'h0);
		rd(oc(0), rv);
		chk(rv & 16'h0c00, 16'h0800);
		fr(11'h123, 1'b0, 1'b1, 4'he);
		u_bus.frame(11'h123, 1'b0, 1'b1);
		tw(1'b0, 4'h0, 1'b0);
		wr(oc(1), cw(8'h00, HUP));
		tw(1'b1, 4'h1, 1'b0);
		u_bus.done();
		tw(1'b0, 4'h0, 1'b0);
		rd(oc(1), rv);
		chk(rv & 16'hf003, 16'h5002);
		wr(oc(0), cw(SND, 8'h00));
		tw(1'b1, 4'h0, 1'b1);
		u_bus.done();
		tw(1'b0, 4'h0, 1'b0);
		u_bus.frame(11'h347, 1'b0, 1'b1);
		tw(1'b0, 4'h0, 1'b0);
		rd(oc(0), rv);
		wr(oc(0), 16'hffff);
		rc(oc(0), rv);
		wr(oc(0), `CANMO_CTL_RESET);
		rc(oc(0), 16'h5555);
		fr(11'h347, 1'b0, 1'b1, 4'he);
		wr(oc(1), cw(8'h00, IRQ));
		iw(1'b0);
		@(posedge I_REF_CLK);
		I_STATUS_EVT <= 1'b1;
		iw(1'b1);
		wr(CT, 16'h000c);
		iw(1'b0);
		stop_test();
	end
endmodule : canmo_setup_tb
